// >>> core/drda_map.svh
// Purpose: Offsets, field positions, reset values and fixed ranges of the resource decode block.
// Assumes: Included by the package and the top module; definitions only.
// Notes: Byte addresses on an Avalon-MM slave with 32-bit data.
//
// Behaviour
// - With bit 31 and the parallel port monitor enable set, I/O cycles to the parallel port range are claimed.
// - With bit 30 set, generic device 13 memory and port hits are claimed, each gated by its own enable.
// - With bit 29 set, generic device 12 memory and port hits are claimed, each gated by its own enable.
// - Bit 28 decodes keyboard ports 60h and 64h; forwarding needs that device's separate forward enable.
// - Bit 27 decodes memory segments A and B for monitoring only and never claims them.
// - Bit 26 decodes VGA ports 3B0h to 3DFh for monitoring only and never claims them.
// - With bit 25 and the game audio range enable set, the game audio ranges are claimed.
// - Bit 24 decodes the frame window given by bits 23:10 for monitoring only, never claiming it.
// - Mask bits 23:22 stand for address bits 21:20, and a one makes the compare ignore that bit.
// - Mask value 10 masks only address bit 21, giving a window in two separate pieces.
// - Base bits 21:10 compare with address bits 31:20 under the mask and feed monitor eleven.
// - Bits 9:8 pick one of four fixed codec audio port ranges.
// - Bit 7 decodes the chosen codec range; forwarding needs device four's forward enable.
// - Each monitored hit is an activity event that reloads the standby timer if its reload enable is set.
`ifndef DRDA_MAP_SVH
`define DRDA_MAP_SVH

// ====================================================================
// Register offsets
`define DRDA_OFF_DEVRES_A 8'h5c
`define DRDA_OFF_COMPANION 8'h80
`define DRDA_OFF_GEN_IO 8'h84
`define DRDA_OFF_GEN_MEM 8'h88
`define DRDA_OFF_RELOAD 8'h8c
`define DRDA_OFF_STATUS 8'h90
`define DRDA_RESET_WORD 32'h0000_0000

// ====================================================================
// Resource A fields
`define DRDA_B_LPT_FWD 31
`define DRDA_B_GEN13_FWD 30
`define DRDA_B_GEN12_FWD 29
`define DRDA_B_KBD_DEC 28
`define DRDA_B_VGA_MEM 27
`define DRDA_B_VGA_PORT 26
`define DRDA_B_GAME_FWD 25
`define DRDA_B_FRAME_DEC 24
`define DRDA_B_CODEC_DEC 7

// ====================================================================
// Companion fields
`define DRDA_B_LPT_MON 0
`define DRDA_B_GEN13_MEM 3
`define DRDA_B_GEN13_PORT 4
`define DRDA_B_GEN12_MEM 5
`define DRDA_B_GEN12_PORT 6
`define DRDA_B_GAME_RANGE 7
`define DRDA_B_KBD_FWD 10
`define DRDA_B_CODEC_FWD 11

// ====================================================================
// Device monitor numbers
`define DRDA_DEV_AUDIO 4
`define DRDA_DEV_LPT 8
`define DRDA_DEV_VIDEO 11
`define DRDA_DEV_GEN12 12
`define DRDA_DEV_GEN13 13
`define DRDA_NUM_DEV 14

// ====================================================================
// Fixed ranges
`define DRDA_KBD_DATA 16'h0060
`define DRDA_KBD_CMD 16'h0064
`define DRDA_VGA_FIRST 16'h03b0
`define DRDA_VGA_LAST 16'h03df
`define DRDA_AB_SEG 15'h0005
`define DRDA_FM_FIRST 16'h0388
`define DRDA_FM_LAST 16'h038b

`endif

// >>> core/drda_pkg.sv
// Purpose: Types shared by the resource decode block.
// Assumes: Constants come from drda_map.svh.
// Notes: None.
`include "drda_map.svh"

package drda_pkg;

   // ====================================================================
   // Carriers
   typedef struct packed {
      logic valid;
      logic is_io;
      logic is_mem;
      logic [31:0] addr;
   } drda_pci_req_s;

   typedef struct packed {
      logic claim;
      logic [`DRDA_NUM_DEV-1:0] activity;
      logic global_reload;
   } drda_decode_s;

   typedef enum logic [1:0] {
      DRDA_BUS_IDLE = 2'b01,
      DRDA_BUS_ACK = 2'b10
   } drda_bus_e;

   typedef struct packed {
      drda_bus_e bus;
      logic waitrequest;
      logic [31:0] readdata;
      logic [31:0] devres_a;
      logic [31:0] companion;
      logic [31:0] gen_io;
      logic [31:0] gen_mem;
      logic [31:0] reload_en;
      logic [31:0] status;
      drda_decode_s dec;
   } drda_state_s;

endpackage

// >>> core/drda_top.sv
// Purpose: Resource decode register and legacy range decoder for the device monitors.
// Assumes: PCI cycle info arrives on sys_clk as a one-cycle valid with address and space.
// Notes: Decode results appear one cycle after the request and are single-cycle pulses.
`timescale 1ns/1ps
`include "drda_map.svh"

module drda_top (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // PCI cycle seen by the decoder
   input wire drda_pkg::drda_pci_req_s pci_req,
   // Decode results
   output drda_pkg::drda_decode_s decode_out
);
   import drda_pkg::*;

   drda_state_s state_q;
   drda_state_s state_d;

   // ====================================================================
   // Helpers
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                               input logic [3:0] be);
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // ====================================================================
   // Register fields
   logic lpt_fwd;
   logic gen13_fwd;
   logic gen12_fwd;
   logic kbd_dec;
   logic vga_mem_dec;
   logic vga_port_dec;
   logic game_fwd;
   logic frame_dec;
   logic [1:0] frame_mask;
   logic [11:0] frame_base;
   logic [1:0] codec_sel;
   logic codec_dec;

   assign lpt_fwd = state_q.devres_a[`DRDA_B_LPT_FWD];
   assign gen13_fwd = state_q.devres_a[`DRDA_B_GEN13_FWD];
   assign gen12_fwd = state_q.devres_a[`DRDA_B_GEN12_FWD];
   assign kbd_dec = state_q.devres_a[`DRDA_B_KBD_DEC];
   assign vga_mem_dec = state_q.devres_a[`DRDA_B_VGA_MEM];
   assign vga_port_dec = state_q.devres_a[`DRDA_B_VGA_PORT];
   assign game_fwd = state_q.devres_a[`DRDA_B_GAME_FWD];
   assign frame_dec = state_q.devres_a[`DRDA_B_FRAME_DEC];
   assign frame_mask = state_q.devres_a[23:22];
   assign frame_base = state_q.devres_a[21:10];
   assign codec_sel = state_q.devres_a[9:8];
   assign codec_dec = state_q.devres_a[`DRDA_B_CODEC_DEC];

   logic lpt_mon;
   logic [1:0] lpt_sel;
   logic gen13_mem_en;
   logic gen13_port_en;
   logic gen12_mem_en;
   logic gen12_port_en;
   logic game_range_en;
   logic [1:0] game_sel;
   logic kbd_fwd;
   logic codec_fwd;

   assign lpt_mon = state_q.companion[`DRDA_B_LPT_MON];
   assign lpt_sel = state_q.companion[2:1];
   assign gen13_mem_en = state_q.companion[`DRDA_B_GEN13_MEM];
   assign gen13_port_en = state_q.companion[`DRDA_B_GEN13_PORT];
   assign gen12_mem_en = state_q.companion[`DRDA_B_GEN12_MEM];
   assign gen12_port_en = state_q.companion[`DRDA_B_GEN12_PORT];
   assign game_range_en = state_q.companion[`DRDA_B_GAME_RANGE];
   assign game_sel = state_q.companion[9:8];
   assign kbd_fwd = state_q.companion[`DRDA_B_KBD_FWD];
   assign codec_fwd = state_q.companion[`DRDA_B_CODEC_FWD];

   // ====================================================================
   // Address qualification
   logic io_cyc;
   logic mem_cyc;
   logic [15:0] port;

   assign io_cyc = pci_req.valid && pci_req.is_io && (pci_req.addr[31:16] == 16'h0000);
   assign mem_cyc = pci_req.valid && pci_req.is_mem;
   assign port = pci_req.addr[15:0];

   // ====================================================================
   // Fixed range decodes
   logic [15:0] lpt_lo;
   logic [15:0] lpt_hi;
   // End points held whole, so no adder sits in the compare path
   logic [15:0] codec_lo;
   logic [15:0] codec_hi;
   logic [15:0] game_lo;
   logic [15:0] game_hi;
   logic [15:0] game_tail_lo;
   logic [15:0] game_tail_hi;

   always_comb begin
      case (lpt_sel)
         2'b00: begin
            lpt_lo = 16'h0378;
            lpt_hi = 16'h037f;
         end
         2'b01: begin
            lpt_lo = 16'h0278;
            lpt_hi = 16'h027f;
         end
         2'b10: begin
            lpt_lo = 16'h03bc;
            lpt_hi = 16'h03be;
         end
         default: begin
            // Reserved select decodes nothing
            lpt_lo = 16'hffff;
            lpt_hi = 16'h0000;
         end
      endcase
   end

   always_comb begin
      // Eight ports from each base
      case (codec_sel)
         2'b00: begin
            codec_lo = 16'h0530;
            codec_hi = 16'h0537;
         end
         2'b01: begin
            codec_lo = 16'h0604;
            codec_hi = 16'h060b;
         end
         2'b10: begin
            codec_lo = 16'h0e80;
            codec_hi = 16'h0e87;
         end
         default: begin
            codec_lo = 16'h0f40;
            codec_hi = 16'h0f47;
         end
      endcase
   end

   always_comb begin
      // Each select opens a 16-port block and a 4-port tail above it
      case (game_sel)
         2'b00: begin
            game_lo = 16'h0220;
            game_hi = 16'h022f;
            game_tail_lo = 16'h0230;
            game_tail_hi = 16'h0233;
         end
         2'b01: begin
            game_lo = 16'h0240;
            game_hi = 16'h024f;
            game_tail_lo = 16'h0250;
            game_tail_hi = 16'h0253;
         end
         2'b10: begin
            game_lo = 16'h0260;
            game_hi = 16'h026f;
            game_tail_lo = 16'h0270;
            game_tail_hi = 16'h0273;
         end
         default: begin
            game_lo = 16'h0280;
            game_hi = 16'h028f;
            game_tail_lo = 16'h0290;
            game_tail_hi = 16'h0293;
         end
      endcase
   end

   logic lpt_hit;
   logic kbd_hit;
   logic vga_port_hit;
   logic vga_mem_hit;
   logic codec_hit;
   logic game_hit;
   logic frame_hit;

   assign lpt_hit = io_cyc && lpt_mon && in_range(port, lpt_lo, lpt_hi);
   assign kbd_hit = io_cyc && kbd_dec && ((port == `DRDA_KBD_DATA) || (port == `DRDA_KBD_CMD));
   assign vga_port_hit = io_cyc && vga_port_dec && in_range(port, `DRDA_VGA_FIRST, `DRDA_VGA_LAST);
   assign vga_mem_hit = mem_cyc && vga_mem_dec && (pci_req.addr[31:17] == `DRDA_AB_SEG);
   assign codec_hit = io_cyc && codec_dec && in_range(port, codec_lo, codec_hi);
   assign game_hit = io_cyc && game_range_en &&
                     (in_range(port, game_lo, game_hi) ||
                      in_range(port, game_tail_lo, game_tail_hi) ||
                      in_range(port, `DRDA_FM_FIRST, `DRDA_FM_LAST));

   // ====================================================================
   // Frame window compare
   logic [11:0] frame_care;

   // Mask bits map to the two lowest compared address bits; 10 leaves a split window
   assign frame_care = {10'h3ff, ~frame_mask};
   assign frame_hit = mem_cyc && frame_dec &&
                      (((pci_req.addr[31:20] ^ frame_base) & frame_care) == 12'h000);

   // ====================================================================
   // Generic devices
   logic gen12_io_hit;
   logic gen13_io_hit;
   logic gen12_mem_hit;
   logic gen13_mem_hit;

   assign gen12_io_hit = io_cyc && gen12_port_en && (port[15:2] == state_q.gen_io[15:2]);
   assign gen13_io_hit = io_cyc && gen13_port_en && (port[15:2] == state_q.gen_io[31:18]);
   assign gen12_mem_hit = mem_cyc && gen12_mem_en && (pci_req.addr[31:16] == state_q.gen_mem[15:0]);
   assign gen13_mem_hit = mem_cyc && gen13_mem_en && (pci_req.addr[31:16] == state_q.gen_mem[31:16]);

   // ====================================================================
   // Claim and activity
   logic claim;
   logic [`DRDA_NUM_DEV-1:0] activity;

   always_comb begin
      claim = 1'b0;
      claim = claim || (lpt_fwd && lpt_hit);
      claim = claim || (gen13_fwd && (gen13_io_hit || gen13_mem_hit));
      claim = claim || (gen12_fwd && (gen12_io_hit || gen12_mem_hit));
      claim = claim || (kbd_fwd && kbd_hit);
      claim = claim || (game_fwd && game_hit);
      claim = claim || (codec_fwd && codec_hit);
      // Video memory, video ports and the frame window never join the claim
   end

   always_comb begin
      activity = '0;
      activity[`DRDA_DEV_AUDIO] = codec_hit || game_hit;
      activity[`DRDA_DEV_LPT] = lpt_hit;
      activity[`DRDA_DEV_VIDEO] = kbd_hit || vga_port_hit || vga_mem_hit || frame_hit;
      activity[`DRDA_DEV_GEN12] = gen12_io_hit || gen12_mem_hit;
      activity[`DRDA_DEV_GEN13] = gen13_io_hit || gen13_mem_hit;
   end

   // ====================================================================
   // Register read mux
   logic [31:0] rd_word;

   always_comb begin
      case (avs_address)
         `DRDA_OFF_DEVRES_A: rd_word = state_q.devres_a;
         `DRDA_OFF_COMPANION: rd_word = state_q.companion;
         `DRDA_OFF_GEN_IO: rd_word = state_q.gen_io;
         `DRDA_OFF_GEN_MEM: rd_word = state_q.gen_mem;
         `DRDA_OFF_RELOAD: rd_word = state_q.reload_en;
         `DRDA_OFF_STATUS: rd_word = state_q.status;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // ====================================================================
   // Next state
   always_comb begin
      state_d = state_q;
      // Decode outputs are one-cycle pulses
      state_d.dec.claim = claim;
      state_d.dec.activity = activity;
      state_d.dec.global_reload = |(activity & state_q.reload_en[`DRDA_NUM_DEV-1:0]);
      if (pci_req.valid) begin
         state_d.status = {15'h0000, claim, 2'b00, activity};
      end
      case (state_q.bus)
         DRDA_BUS_IDLE: begin
            state_d.waitrequest = 1'b1;
            if (avs_read || avs_write) begin
               state_d.bus = DRDA_BUS_ACK;
               state_d.waitrequest = 1'b0;
               state_d.readdata = avs_read ? rd_word : 32'h0000_0000;
            end
         end
         DRDA_BUS_ACK: begin
            // Write lands at the edge where the master sees waitrequest low
            state_d.bus = DRDA_BUS_IDLE;
            state_d.waitrequest = 1'b1;
            if (avs_write) begin
               case (avs_address)
                  `DRDA_OFF_DEVRES_A:
                     state_d.devres_a = merge_bytes(state_q.devres_a, avs_writedata, avs_byteenable);
                  `DRDA_OFF_COMPANION:
                     state_d.companion = merge_bytes(state_q.companion, avs_writedata, avs_byteenable);
                  `DRDA_OFF_GEN_IO:
                     state_d.gen_io = merge_bytes(state_q.gen_io, avs_writedata, avs_byteenable);
                  `DRDA_OFF_GEN_MEM:
                     state_d.gen_mem = merge_bytes(state_q.gen_mem, avs_writedata, avs_byteenable);
                  `DRDA_OFF_RELOAD:
                     state_d.reload_en = merge_bytes(state_q.reload_en, avs_writedata, avs_byteenable);
                  default: begin
                     // Unmapped and read-only words ignore writes
                  end
               endcase
            end
         end
         default: begin
            state_d.bus = DRDA_BUS_IDLE;
            state_d.waitrequest = 1'b1;
         end
      endcase
   end

   // ====================================================================
   // State register
   // Synchronous reset: every field cleared, decode pulses included, except waitrequest set high and bus set to idle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q.bus <= DRDA_BUS_IDLE;
         state_q.waitrequest <= 1'b1;
         state_q.readdata <= 32'h0000_0000;
         state_q.devres_a <= `DRDA_RESET_WORD;
         state_q.companion <= `DRDA_RESET_WORD;
         state_q.gen_io <= `DRDA_RESET_WORD;
         state_q.gen_mem <= `DRDA_RESET_WORD;
         state_q.reload_en <= `DRDA_RESET_WORD;
         state_q.status <= `DRDA_RESET_WORD;
         state_q.dec <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign avs_readdata = state_q.readdata;
   assign avs_waitrequest = state_q.waitrequest;
   assign decode_out = state_q.dec;

endmodule

// >>> tb/drda_asserts.sv
// Purpose: Port-level checks on the resource decode block.
// Assumes: Bound to drda_top; resource A mirrored from acked writes.
// Notes: Decode checks look one cycle after the valid pulse.
`timescale 1ns/1ps
`include "drda_map.svh"

module drda_asserts (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Decoder
   input wire drda_pkg::drda_pci_req_s pci_req,
   input wire drda_pkg::drda_decode_s decode_out
);
   import drda_pkg::*;
   logic [31:0] sh_d;
   logic [31:0] sh_q;
   logic cyc_io;
   logic cyc_mem;
   // ====================================================================
   // Mirror of resource A
   always_comb begin
      sh_d = sh_q;
      if (avs_write && !avs_waitrequest && avs_address == `DRDA_OFF_DEVRES_A) begin
         for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
               sh_d[8*i +: 8] = avs_writedata[8*i +: 8];
            end
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      sh_q <= rst ? 32'h0000_0000 : sh_d;
   end
   assign cyc_io = pci_req.valid && pci_req.is_io && !pci_req.is_mem;
   assign cyc_mem = pci_req.valid && pci_req.is_mem && !pci_req.is_io;
   // ====================================================================
   // Properties
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered after one cycle");
   a_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held longer than one cycle");
   a_read_back: assert property (avs_read && !avs_waitrequest && avs_address == `DRDA_OFF_DEVRES_A |-> avs_readdata == sh_q)
      else $error("resource word read differs from written value");
   a_start_clear: assert property ($fell(rst) |-> decode_out == '0 && avs_waitrequest && avs_readdata == 32'h0000_0000)
      else $error("outputs not cleared by reset");
   a_idle_quiet: assert property (!pci_req.valid |=> decode_out == '0)
      else $error("decode pulse without a cycle");
   a_reload_cause: assert property (decode_out.global_reload |-> decode_out.activity != 14'h0000)
      else $error("timer reload without activity");
   a_ab_unclaimed: assert property (cyc_mem && pci_req.addr[31:17] == `DRDA_AB_SEG |=> !decode_out.claim)
      else $error("legacy video memory claimed");
   a_vga_unclaimed: assert property (cyc_io && !sh_q[31] && pci_req.addr >= 32'h0000_03b0 && pci_req.addr <= 32'h0000_03df
      |=> !decode_out.claim)
      else $error("video port claimed");
   a_kbd_seen: assert property (cyc_io && sh_q[28] && (pci_req.addr == 32'h0000_0060 || pci_req.addr == 32'h0000_0064)
      |=> decode_out.activity[11])
      else $error("keyboard port not seen by monitor eleven");
   a_frame_seen: assert property (cyc_mem && sh_q[24]
      && ((pci_req.addr[31:20] ^ sh_q[21:10]) & {10'h3ff, ~sh_q[23], ~sh_q[22]}) == 12'h000
      |=> decode_out.activity[11])
      else $error("frame window hit not seen by monitor eleven");
endmodule

bind drda_top drda_asserts u_drda_asserts (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pci_req(pci_req), .decode_out(decode_out));

// >>> tb/drda_pci_model.sv
// Purpose: PCI master stand-in presenting cycles to the decoder.
// Assumes: One-cycle valid launched just after a rising edge.
// Notes: Idle address is inverted so a stale value never matches.
`timescale 1ns/1ps

module drda_pci_model (
   // Clock
   input wire logic sys_clk,
   // Cycle to the decoder
   output drda_pkg::drda_pci_req_s pci_req
);
   import drda_pkg::*;
   initial begin
      pci_req = '0;
   end
   task automatic cycle(input logic io, input logic mem, input logic [31:0] addr);
      @(posedge sys_clk);
      pci_req <= '{valid: 1'h1, is_io: io, is_mem: mem, addr: addr};
      @(posedge sys_clk);
      pci_req <= '{valid: 1'h0, is_io: 1'h0, is_mem: 1'h0, addr: ~addr};
   endtask
endmodule

// >>> tb/test_device_resource_decode_a.sv
// Purpose: Self-checking bench for the resource decode block.
// Assumes: Generic windows at ports 300h/200h and memory D000/C000.
// Notes: Only monitor eleven reloads the timer.
`timescale 1ns/1ps
`include "drda_map.svh"

module test_device_resource_decode_a;
   import drda_pkg::*;
   typedef struct packed {
      logic [31:0] a;
      logic [11:0] c;
      logic io;
      logic [31:0] ad;
      logic cl;
      logic [13:0] act;
   } drda_row_s;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h0;
   wire logic [31:0] avs_readdata;
   wire logic avs_waitrequest;
   wire drda_pci_req_s pci_req;
   wire drda_decode_s decode_out;
   int error_cnt = 0;
   int cmp_count = 0;
   logic [31:0] rd;
   drda_row_s rows [0:26] = '{
      '{32'h8000_0000, 12'h001, 1'h1, 32'h0000_0378, 1'h1, 14'h0100},
      '{32'h4000_0000, 12'h008, 1'h0, 32'hd000_0010, 1'h1, 14'h2000},
      '{32'h4000_0000, 12'h010, 1'h1, 32'h0000_0302, 1'h1, 14'h2000},
      '{32'h4000_0000, 12'h010, 1'h0, 32'hd000_0010, 1'h0, 14'h0000},
      '{32'h2000_0000, 12'h020, 1'h0, 32'hc000_1234, 1'h1, 14'h1000},
      '{32'h2000_0000, 12'h040, 1'h1, 32'h0000_0201, 1'h1, 14'h1000},
      '{32'h1000_0000, 12'h000, 1'h1, 32'h0000_0064, 1'h0, 14'h0800},
      '{32'h1000_0000, 12'h400, 1'h1, 32'h0000_0060, 1'h1, 14'h0800},
      '{32'h0800_0000, 12'hfff, 1'h0, 32'h000b_fffc, 1'h0, 14'h0800},
      '{32'h0400_0000, 12'hfff, 1'h1, 32'h0000_03df, 1'h0, 14'h0800},
      '{32'h0200_0000, 12'h080, 1'h1, 32'h0000_022f, 1'h1, 14'h0010},
      '{32'h0200_0000, 12'h080, 1'h1, 32'h0000_0389, 1'h1, 14'h0010},
      '{32'h0200_0000, 12'h380, 1'h1, 32'h0000_0293, 1'h1, 14'h0010},
      '{32'h0200_0000, 12'h000, 1'h1, 32'h0000_0220, 1'h0, 14'h0000},
      '{32'h0104_8c00, 12'hfff, 1'h0, 32'h1230_0000, 1'h0, 14'h0800},
      '{32'h0104_8c00, 12'h000, 1'h0, 32'h1200_0000, 1'h0, 14'h0000},
      '{32'h01c4_8c00, 12'h000, 1'h0, 32'h1200_0000, 1'h0, 14'h0800},
      '{32'h0184_8c00, 12'h000, 1'h0, 32'h1210_0000, 1'h0, 14'h0800},
      '{32'h0184_8c00, 12'h000, 1'h0, 32'h1220_0000, 1'h0, 14'h0000},
      '{32'h0000_0080, 12'h800, 1'h1, 32'h0000_0537, 1'h1, 14'h0010},
      '{32'h0000_0180, 12'h800, 1'h1, 32'h0000_0604, 1'h1, 14'h0010},
      '{32'h0000_0380, 12'h800, 1'h1, 32'h0000_0f47, 1'h1, 14'h0010},
      '{32'h0000_0080, 12'h000, 1'h1, 32'h0000_0530, 1'h0, 14'h0010},
      '{32'h0000_0300, 12'h800, 1'h1, 32'h0000_0f40, 1'h0, 14'h0000},
      '{32'h0000_0280, 12'h800, 1'h1, 32'h0000_0e80, 1'h1, 14'h0010},
      '{32'h8000_0000, 12'h005, 1'h1, 32'h0000_03be, 1'h1, 14'h0100},
      '{32'h0200_0000, 12'h180, 1'h1, 32'h0000_0253, 1'h1, 14'h0010}
   };

   always #12.5 sys_clk = ~sys_clk;

   drda_top dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pci_req(pci_req), .decode_out(decode_out));
   drda_pci_model pci (.sys_clk(sys_clk), .pci_req(pci_req));

   // ====================================================================
   // Tasks
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (avs_waitrequest !== 1'h0) begin
         chk("bus answer", 32'h0000_0000, 32'h0000_0001);
         end_sim();
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d, 4'hf, rd);
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0000_0000, 4'h0, rd);
      chk(what, exp, rd);
   endtask
   task automatic run_row(input drda_row_s r);
      wreg(`DRDA_OFF_DEVRES_A, r.a);
      wreg(`DRDA_OFF_COMPANION, {20'h0_0000, r.c});
      pci.cycle(r.io, ~r.io, r.ad);
      #1;
      chk("claim", {31'h0000_0000, r.cl}, {31'h0000_0000, decode_out.claim});
      chk("activity", {18'h0_0000, r.act}, {18'h0_0000, decode_out.activity});
      chk("reload", {31'h0000_0000, r.act[11]}, {31'h0000_0000, decode_out.global_reload});
   endtask

   // ====================================================================
   // Sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'h0;
      rchk("reset word", `DRDA_OFF_DEVRES_A, 32'h0000_0000);
      wreg(`DRDA_OFF_GEN_IO, 32'h0300_0200);
      wreg(`DRDA_OFF_GEN_MEM, 32'hd000_c000);
      wreg(`DRDA_OFF_RELOAD, 32'h0000_0800);
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      rchk("status word", `DRDA_OFF_STATUS, 32'h0001_0010);
      wreg(`DRDA_OFF_DEVRES_A, 32'ha5a5_5a5a);
      bus(1'h1, `DRDA_OFF_DEVRES_A, 32'hffff_ffff, 4'h2, rd);
      rchk("byte lanes", `DRDA_OFF_DEVRES_A, 32'ha5a5_ff5a);
      rchk("unmapped", 8'h40, 32'h0000_0000);
      // Resource A all ones, then a reset in mid-run must clear it all
      wreg(`DRDA_OFF_DEVRES_A, 32'hffff_ffff);
      rst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      rchk("word after reset", `DRDA_OFF_DEVRES_A, 32'h0000_0000);
      pci.cycle(1'h1, 1'h0, 32'h0000_0060);
      #1;
      chk("decode after reset", 32'h0000_0000, {17'h0_0000, decode_out.claim, decode_out.activity});
      end_sim();
   end
endmodule
